// ---- rtl/drive_cfg_pkg.sv ----
/*
  Constants, register map and carrier types of the power-on configuration
  loader of a servo drive. Assumes a single 100 MHz clock domain.
*/
// Summary of operation
// - Proprietary CAN mode auto-starts the stored motion program when one is present.
// - Nonvolatile word at 0x4000 equal to 1 suppresses auto-start; software may write it.
// - All Hall inputs low at power-on on CAN: slave mode, no auto-start, no program.
// - Once the nonvolatile disable flag is set, Hall inputs no longer matter.
// - EtherCAT variant: all Hall inputs low at power-on invalidates the setup table.
// - After invalidation, next power-on loads defaults and sets error register bit 2.
// - EtherCAT variant always runs CoE; nothing changes that mode.
// - EtherCAT axis ID comes from software, range 1-255; unconfigured gives 255.
// - EtherCAT with hardware-strapped axis ID selected uses axis ID 255.
// - Node-address addressing: axis ID 255 gives station alias 0.
// - Node-address addressing: axis ID 1 to 254 is copied into the station alias.
// - CAN variant resolves three straps into levels 0 to 6, ground to supply.
// - Third strap selects mode: levels 0-2 CANopen, levels 3-6 proprietary CAN.
// - Axis ID = 49 x adjusted third + 7 x second + first; proprietary subtracts 3.
// - Proprietary mode: computed axis ID zero becomes 255.
`default_nettype none
package drive_cfg_pkg;

  // Strap levels
  localparam int LVL_W = 3;
  localparam logic [2:0] STRAP_LEVEL_GROUND = 3'h0;
  localparam logic [2:0] STRAP_LEVEL_OPEN = 3'h3;
  localparam logic [2:0] STRAP_LEVEL_SUPPLY = 3'h6;
  localparam logic [2:0] LVL_CANOPEN_MAX = 3'h2;

  // Axis ID arithmetic
  localparam logic [7:0] HIGH_WEIGHT = 8'h31;
  localparam logic [7:0] MID_WEIGHT = 8'h07;
  localparam logic [2:0] PROP_HIGH_OFFSET = 3'h3;
  localparam logic [7:0] ID_UNSET = 8'hFF;
  localparam logic [7:0] ID_CANOPEN_ZERO = 8'h7F;
  localparam logic [7:0] ID_CANOPEN_MAX = 8'h7E;
  localparam logic [7:0] ID_ZERO = 8'h00;
  localparam logic [15:0] ALIAS_NONE = 16'h0000;

  // Nonvolatile auto-start disable word
  localparam logic [15:0] NV_DISABLE_ADDR = 16'h4000;
  localparam logic [15:0] NV_DISABLE_VAL = 16'h0001;
  localparam int MERR_DEFAULTS_BIT = 2;

  // Strap settle time after reset release
  localparam int CLK_PERIOD_NS = 10;
  localparam int STRAP_SETTLE_NS = 10000;
  localparam int SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [7:0] REG_CFG_STATUS = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_AXIS_SW = 8'h08;
  localparam logic [7:0] REG_MERR = 8'h0C;
  localparam logic [7:0] REG_ALIAS = 8'h10;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h14;
  localparam logic [7:0] REG_IRQ_MASK = 8'h18;

  // Control fields and reset values
  localparam int CTRL_NV_DISABLE_BIT = 0;
  localparam int CTRL_HW_AXIS_BIT = 1;
  localparam int CTRL_NODE_ADDR_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h4;

  // Interrupt events
  localparam int IRQ_W = 3;
  localparam int IRQ_CFG_DONE = 0;
  localparam int IRQ_AUTORUN_OFF = 1;
  localparam int IRQ_SETUP_INVAL = 2;

  typedef enum logic [1:0] {MODE_CANOPEN, MODE_PROP_CAN, MODE_COE} proto_mode_t;

  typedef enum logic [1:0] {ST_SETTLE, ST_SAMPLE, ST_DONE} cfg_state_t;

  typedef struct packed {
    logic [LVL_W-1:0] high;
    logic [LVL_W-1:0] mid;
    logic [LVL_W-1:0] low;
  } strap_pins_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
    logic stb;
  } nv_write_t;

endpackage
`default_nettype wire

// ---- rtl/drive_id_mode_strap_decoder.sv ----
/*
  Power-on configuration loader: resolves the straps into operating mode and
  axis ID, decides auto-start and setup invalidation, and maps the axis ID to
  the station alias. Assumes an AHB-Lite master with a single slave, and a
  nonvolatile store controller on mclk that presents its first word and flags.
*/
`default_nettype none
module drive_id_mode_strap_decoder
  import drive_cfg_pkg::*;
#(
  parameter int HALL_W = 3,
  parameter int SETTLE_CYCLES = SETTLE_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Board pins, asynchronous
  input wire strap_pins_t strap_pins,
  input wire logic [HALL_W-1:0] hall_in,
  input wire logic ethercat_variant,
  // Nonvolatile store, on mclk
  input wire logic nv_ready,
  input wire logic [15:0] nv_word0,
  input wire logic nv_program_present,
  input wire logic nv_setup_invalid,
  output nv_write_t nv_wr,
  output logic setup_invalidate_stb,
  // Configuration results
  output logic cfg_done,
  output proto_mode_t proto_mode,
  output logic [7:0] axis_id,
  output logic [15:0] station_alias,
  output logic autorun_en,
  output logic run_program,
  output logic load_defaults,
  output logic [15:0] motion_error_register,
  output logic irq
);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  localparam int PIN_W = 3 * LVL_W + HALL_W + 1;
  logic [PIN_W-1:0] pin_s1_ff, pin_s2_ff, pin_s3_ff, pin_st_ff;
  strap_pins_t strap_st;
  logic [HALL_W-1:0] hall_st;
  logic cat_st;

  // Three stages; a value counts once stages two and three agree
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      pin_s3_ff <= '0;
    end else begin
      pin_s1_ff <= {strap_pins, hall_in, ethercat_variant};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  // Whole vector must agree, so a half-settled level code is never taken
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_st_ff <= '0;
    end else if (pin_s2_ff == pin_s3_ff) begin
      pin_st_ff <= pin_s3_ff;
    end
  end

  assign strap_st = pin_st_ff[PIN_W-1 -: 3*LVL_W];
  assign hall_st = pin_st_ff[HALL_W:1];
  assign cat_st = pin_st_ff[0];

  // ==========================================================================
  // Power-on sequencer
  // ==========================================================================
  cfg_state_t state_ff;
  logic [$clog2(SETTLE_CYCLES+1)-1:0] settle_cnt_ff;
  logic settle_over;
  logic sample;

  assign settle_over = (settle_cnt_ff == ($bits(settle_cnt_ff))'(SETTLE_CYCLES));
  assign sample = (state_ff == ST_SAMPLE);

  // Waits for the straps to settle and the store to present its word
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      settle_cnt_ff <= '0;
    end else if (!settle_over) begin
      settle_cnt_ff <= settle_cnt_ff + 1'b1;
    end
  end

  // Sampling happens exactly once per reset, which stands for power-on
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_ff <= ST_SETTLE;
    end else begin
      case (state_ff)
        ST_SETTLE: begin
          if (settle_over && nv_ready) begin
            state_ff <= ST_SAMPLE;
          end
        end
        ST_SAMPLE: state_ff <= ST_DONE;
        ST_DONE: state_ff <= ST_DONE;
        default: state_ff <= ST_SETTLE;
      endcase
    end
  end

  // ==========================================================================
  // Strap decode
  // ==========================================================================
  function automatic logic [2:0] clamp_lvl(input logic [2:0] lvl);
    clamp_lvl = (lvl > STRAP_LEVEL_SUPPLY) ? STRAP_LEVEL_SUPPLY : lvl;
  endfunction

  logic [2:0] lvl_hi, lvl_mid, lvl_lo, hi_adj;
  logic is_prop, hall_all_low, nv_disabled;
  logic [7:0] id_raw, can_id;

  // Levels ground..supply as 0..6; out-of-range sensing clamps to supply
  always_comb begin
    lvl_hi = clamp_lvl(strap_st.high);
    lvl_mid = clamp_lvl(strap_st.mid);
    lvl_lo = clamp_lvl(strap_st.low);
    is_prop = (lvl_hi > LVL_CANOPEN_MAX);
    hi_adj = is_prop ? (lvl_hi - PROP_HIGH_OFFSET) : lvl_hi;
    id_raw = HIGH_WEIGHT * {5'h00, hi_adj} + MID_WEIGHT * {5'h00, lvl_mid}
      + {5'h00, lvl_lo};
    if (is_prop) begin
      can_id = (id_raw == ID_ZERO) ? ID_UNSET : id_raw;
    end else if (id_raw == ID_ZERO) begin
      can_id = ID_CANOPEN_ZERO;
    end else begin
      // CANopen node numbers stop at 126; higher codes fall back to unset
      can_id = (id_raw > ID_CANOPEN_MAX) ? ID_UNSET : id_raw;
    end
  end

  assign hall_all_low = ~|hall_st;
  assign nv_disabled = (nv_word0 == NV_DISABLE_VAL);

  // ==========================================================================
  // Register file over AHB-Lite
  // ==========================================================================
  logic wr_pend_ff;
  logic [7:0] wr_addr_ff;
  logic [2:0] ctrl_ff;
  logic [7:0] axis_sw_ff;
  logic [IRQ_W-1:0] irq_status_ff, irq_mask_ff, irq_set;
  logic [31:0] rd_mux;
  logic accept;
  logic wr_ctrl, wr_axis, wr_irq_st, wr_irq_mask;
  logic cat_ff;

  assign accept = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wr_ctrl = wr_pend_ff && (wr_addr_ff == REG_CTRL);
  assign wr_axis = wr_pend_ff && (wr_addr_ff == REG_AXIS_SW);
  assign wr_irq_st = wr_pend_ff && (wr_addr_ff == REG_IRQ_STATUS);
  assign wr_irq_mask = wr_pend_ff && (wr_addr_ff == REG_IRQ_MASK);

  // Address phase is latched; write data arrives in the next cycle
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
    end else begin
      wr_pend_ff <= accept && hwrite;
      wr_addr_ff <= {haddr[7:2], 2'b00};
    end
  end

  // Read mux; unmapped offsets read zero with an OKAY response
  always_comb begin
    rd_mux = '0;
    case ({haddr[7:2], 2'b00})
      REG_CFG_STATUS: rd_mux = {16'h0000, axis_id, 1'b0, cat_ff, load_defaults,
        run_program, autorun_en, proto_mode, cfg_done};
      REG_CTRL: rd_mux = {29'h0, ctrl_ff[CTRL_NODE_ADDR_BIT:CTRL_HW_AXIS_BIT], 1'b0};
      REG_AXIS_SW: rd_mux = {24'h0, axis_sw_ff};
      REG_MERR: rd_mux = {16'h0000, motion_error_register};
      REG_ALIAS: rd_mux = {16'h0000, station_alias};
      REG_IRQ_STATUS: rd_mux = {29'h0, irq_status_ff};
      REG_IRQ_MASK: rd_mux = {29'h0, irq_mask_ff};
      default: rd_mux = '0;
    endcase
  end

  // Read data is captured at the address phase so it stands from a flop
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hrdata <= '0;
    end else if (accept && !hwrite) begin
      hrdata <= rd_mux;
    end
  end

  // Control: disable command is write-one, the other bits persist
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_ff <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_ff <= hwdata[2:0];
    end else begin
      ctrl_ff[CTRL_NV_DISABLE_BIT] <= 1'b0;
    end
  end

  // Software axis ID, zero meaning not configured
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      axis_sw_ff <= ID_ZERO;
    end else if (wr_axis) begin
      axis_sw_ff <= hwdata[7:0];
    end
  end

  // Host request to store the auto-start disable word
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      nv_wr <= '0;
    end else begin
      nv_wr.addr <= NV_DISABLE_ADDR;
      nv_wr.data <= NV_DISABLE_VAL;
      nv_wr.stb <= ctrl_ff[CTRL_NV_DISABLE_BIT];
    end
  end

  // ==========================================================================
  // Configuration results
  // ==========================================================================
  // Latched once at sampling; later strap moves are ignored until reset
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cat_ff <= 1'b0;
      proto_mode <= MODE_CANOPEN;
      autorun_en <= 1'b0;
      run_program <= 1'b0;
      load_defaults <= 1'b0;
      setup_invalidate_stb <= 1'b0;
      cfg_done <= 1'b0;
    end else begin
      setup_invalidate_stb <= 1'b0;
      if (sample) begin
        cfg_done <= 1'b1;
        cat_ff <= cat_st;
        if (cat_st) begin
          proto_mode <= MODE_COE;
          autorun_en <= 1'b0;
          run_program <= 1'b0;
          load_defaults <= nv_setup_invalid;
          setup_invalidate_stb <= hall_all_low;
        end else begin
          proto_mode <= is_prop ? MODE_PROP_CAN : MODE_CANOPEN;
          // Stored flag outranks the Hall inputs
          autorun_en <= is_prop && !nv_disabled && !hall_all_low;
          run_program <= is_prop && !nv_disabled && !hall_all_low
            && nv_program_present;
          load_defaults <= 1'b0;
        end
      end
    end
  end

  // Error register; only the defaults-loaded bit lives here
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      motion_error_register <= '0;
    end else if (sample && cat_st && nv_setup_invalid) begin
      motion_error_register[MERR_DEFAULTS_BIT] <= 1'b1;
    end
  end

  // Axis ID: straps on CAN, software value on EtherCAT after power-on
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      axis_id <= ID_UNSET;
    end else if (sample && !cat_st) begin
      axis_id <= can_id;
    end else if (cfg_done && cat_ff) begin
      if (ctrl_ff[CTRL_HW_AXIS_BIT] || axis_sw_ff == ID_ZERO) begin
        axis_id <= ID_UNSET;
      end else begin
        axis_id <= axis_sw_ff;
      end
    end
  end

  // Station alias follows the axis ID one cycle later in node addressing
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      station_alias <= ALIAS_NONE;
    end else if (!(cfg_done && cat_ff && ctrl_ff[CTRL_NODE_ADDR_BIT])) begin
      station_alias <= ALIAS_NONE;
    end else if (axis_id == ID_UNSET) begin
      station_alias <= ALIAS_NONE;
    end else begin
      station_alias <= {8'h00, axis_id};
    end
  end

  // ==========================================================================
  // Interrupts
  // ==========================================================================
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_CFG_DONE] = sample;
    irq_set[IRQ_AUTORUN_OFF] = sample && !cat_st && is_prop
      && (nv_disabled || hall_all_low);
    irq_set[IRQ_SETUP_INVAL] = sample && cat_st && hall_all_low;
  end

  // Sticky status; an event in the clearing cycle wins over the clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_status_ff <= '0;
    end else begin
      irq_status_ff <= (irq_status_ff & ~(wr_irq_st ? hwdata[IRQ_W-1:0] : '0)) | irq_set;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_mask_ff <= '0;
    end else if (wr_irq_mask) begin
      irq_mask_ff <= hwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_ff & irq_mask_ff);
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  property p_coe_fixed;
    cfg_done && cat_ff |-> proto_mode == MODE_COE;
  endproperty
  a_coe_fixed: assert property (p_coe_fixed) else $error("CoE mode lost");

  property p_nv_disable;
    sample && nv_disabled && !cat_st |=> !autorun_en && !run_program;
  endproperty
  a_nv_disable: assert property (p_nv_disable) else $error("auto-start not off");

  property p_hall_slave;
    sample && !cat_st && hall_all_low |=> !autorun_en && !run_program;
  endproperty
  a_hall_slave: assert property (p_hall_slave) else $error("Hall slave ignored");

  property p_autostart;
    sample && !cat_st && is_prop && !nv_disabled && !hall_all_low && nv_program_present
      |=> autorun_en && run_program && proto_mode == MODE_PROP_CAN;
  endproperty
  a_autostart: assert property (p_autostart) else $error("program not started");

  property p_invalidate;
    sample && cat_st && hall_all_low |=> setup_invalidate_stb ##1 !setup_invalidate_stb;
  endproperty
  a_invalidate: assert property (p_invalidate) else $error("setup not invalidated");

  property p_defaults;
    sample && cat_st && nv_setup_invalid
      |=> load_defaults && motion_error_register[MERR_DEFAULTS_BIT];
  endproperty
  a_defaults: assert property (p_defaults) else $error("defaults not loaded");

  property p_alias_zero;
    cfg_done && cat_ff && ctrl_ff[CTRL_NODE_ADDR_BIT] && axis_id == ID_UNSET
      ##1 ctrl_ff[CTRL_NODE_ADDR_BIT] |-> station_alias == ALIAS_NONE;
  endproperty
  a_alias_zero: assert property (p_alias_zero) else $error("alias not zero");

  property p_alias_copy;
    cfg_done && cat_ff && ctrl_ff[CTRL_NODE_ADDR_BIT] && axis_id != ID_UNSET
      ##1 ctrl_ff[CTRL_NODE_ADDR_BIT] |-> station_alias == {8'h00, $past(axis_id)};
  endproperty
  a_alias_copy: assert property (p_alias_copy) else $error("alias not copied");

  property p_prop_zero;
    sample && !cat_st && lvl_hi == STRAP_LEVEL_OPEN && lvl_mid == STRAP_LEVEL_GROUND
      && lvl_lo == STRAP_LEVEL_GROUND |=> axis_id == ID_UNSET;
  endproperty
  a_prop_zero: assert property (p_prop_zero) else $error("zero ID not 255");

  property p_canopen_zero;
    sample && !cat_st && lvl_hi == STRAP_LEVEL_GROUND && lvl_mid == STRAP_LEVEL_GROUND
      && lvl_lo == STRAP_LEVEL_GROUND |=> axis_id == ID_CANOPEN_ZERO ##1 cfg_done;
  endproperty
  a_canopen_zero: assert property (p_canopen_zero) else $error("zero ID not 127");

  property p_hw_axis;
    cfg_done && cat_ff && ctrl_ff[CTRL_HW_AXIS_BIT] |=> axis_id == ID_UNSET;
  endproperty
  a_hw_axis: assert property (p_hw_axis) else $error("hw axis not 255");

endmodule
`default_nettype wire

// ---- tb/board_strap_model.sv ----
/*
  Far-side model of the power-on loader: strap resistors, Hall lines and the
  nonvolatile store. Assumes the bench sets the board up and clears the store.
*/
`default_nettype none
module board_strap_model
  import drive_cfg_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Board set-up from the bench
  input wire strap_pins_t set_straps,
  input wire logic [2:0] set_hall,
  input wire logic set_prog,
  input wire logic wipe_nv,
  input wire logic [3:0] ready_dly,
  // Requests from the loader
  input wire nv_write_t nv_wr,
  input wire logic setup_invalidate_stb,
  // Pins and store toward the loader
  output strap_pins_t strap_pins,
  output logic [2:0] hall_in,
  output logic nv_ready,
  output logic [15:0] nv_word0,
  output logic nv_program_present,
  output logic nv_setup_invalid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] word0_ff;
  logic inval_ff;
  logic [3:0] wait_ff;
  // Resistors only: levels follow the board set-up
  assign strap_pins = set_straps;
  assign hall_in = set_hall;
  // Not kind while busy: contents show inverted until ready
  assign nv_word0 = nv_ready ? word0_ff : ~word0_ff;
  assign nv_setup_invalid = nv_ready ? inval_ff : ~inval_ff;
  assign nv_program_present = nv_ready ? set_prog : ~set_prog;
  // Store answers promptly or late after each power-on
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wait_ff <= 4'h0;
      nv_ready <= 1'b0;
    end else if (wait_ff >= ready_dly) begin
      nv_ready <= 1'b1;
    end else begin
      wait_ff <= wait_ff + 4'h1;
    end
  end
  // Contents survive reset; only the bench wipes them
  always_ff @(posedge mclk) begin
    if (wipe_nv) begin
      word0_ff <= 16'h0000;
      inval_ff <= 1'b0;
    end else begin
      if (nv_wr.stb && nv_wr.addr == NV_DISABLE_ADDR) word0_ff <= nv_wr.data;
      if (setup_invalidate_stb) inval_ff <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- tb/drive_id_mode_strap_decoder_tb.sv ----
/*
  Self-checking bench of the power-on loader: repeated power-ons over strap,
  Hall and store cases, AHB-Lite register traffic and the interrupt.
  Assumes the loader answers the bus with zero wait states.
*/
`default_nettype none
module drive_id_mode_strap_decoder_tb
  import drive_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, sys_rst = 1, hsel = 0, hwrite = 0, ethercat = 0, set_prog = 0, wipe_nv = 1;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, got_cfg;
  logic [2:0] hsize = 3'h2, set_hall = 3'h7, hall_in;
  logic [3:0] ready_dly = 4'h0;
  strap_pins_t set_straps = 9'h0, strap_pins;
  wire logic hready, hreadyout;
  logic hresp, nv_ready, nv_program_present, nv_setup_invalid, setup_invalidate_stb, cfg_done;
  logic autorun_en, run_program, load_defaults, irq, seen_done = 0, exp_dis = 0, exp_inv = 0;
  logic [15:0] nv_word0, station_alias, motion_error_register;
  logic [7:0] axis_id;
  nv_write_t nv_wr;
  proto_mode_t proto_mode;
  logic [31:0] exp_queue[$];
  int fail_count = 0, compares = 0, seed = 90, k;
  logic [8:0] cases[6] = '{9'o000, 9'o300, 9'o240, 9'o241, 9'o666, 9'o266};
  logic [7:0] sw_ids[4] = '{8'h21, 8'hFE, 8'hFF, 8'h01};
  // ==========================================================
  // Clock, bus loop-back and instances
  always #5 mclk = ~mclk;
  assign hready = hreadyout;
  drive_id_mode_strap_decoder #(.HALL_W(3), .SETTLE_CYCLES(8)) dut (.mclk(mclk),
    .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .strap_pins(strap_pins), .hall_in(hall_in), .ethercat_variant(ethercat),
    .nv_ready(nv_ready), .nv_word0(nv_word0), .nv_program_present(nv_program_present),
    .nv_setup_invalid(nv_setup_invalid), .nv_wr(nv_wr),
    .setup_invalidate_stb(setup_invalidate_stb), .cfg_done(cfg_done), .proto_mode(proto_mode),
    .axis_id(axis_id), .station_alias(station_alias), .autorun_en(autorun_en),
    .run_program(run_program), .load_defaults(load_defaults),
    .motion_error_register(motion_error_register), .irq(irq));
  board_strap_model model (.mclk(mclk), .sys_rst(sys_rst), .set_straps(set_straps),
    .set_hall(set_hall), .set_prog(set_prog), .wipe_nv(wipe_nv), .ready_dly(ready_dly),
    .nv_wr(nv_wr), .setup_invalidate_stb(setup_invalidate_stb), .strap_pins(strap_pins),
    .hall_in(hall_in), .nv_ready(nv_ready), .nv_word0(nv_word0),
    .nv_program_present(nv_program_present), .nv_setup_invalid(nv_setup_invalid));
  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    if (fail_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // One single-word transfer; waits on hready, never a fixed count
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do begin
      @(posedge mclk);
    end while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge mclk);
    end while (hready !== 1'b1);
    rd = hrdata;
    check("hresp", 32'h0, {31'h0, hresp});
  endtask
  // Expected loader result, packed as the monitor packs the outputs
  function automatic logic [31:0] expect_cfg(logic [8:0] s, logic [2:0] hl, logic eth, logic pr);
    int h, v;
    logic prop, au, ld;
    logic [1:0] md;
    h = s[8:6];
    prop = h >= 3;
    v = 49 * (prop ? h - 3 : h) + 7 * s[5:3] + s[2:0];
    if (prop && v == 0) v = 255;
    else if (!prop && v == 0) v = 127;
    else if (!prop && v > 126) v = 255;
    md = prop ? MODE_PROP_CAN : MODE_CANOPEN;
    au = prop && !exp_dis && hl != 3'h0;
    if (eth) begin
      md = MODE_COE;
      v = 255;
      au = 1'b0;
    end
    ld = eth && exp_inv;
    return {18'h0, ld, au && pr, au, md, v[7:0], ld};
  endfunction
  // Power cycle with a new board set-up; the note goes in before release
  task automatic power_on(input logic [8:0] s, input logic [2:0] hl, input logic eth,
                          input logic pr);
    @(posedge mclk);
    sys_rst <= 1'b1;
    set_straps <= s;
    set_hall <= hl;
    ethercat <= eth;
    set_prog <= pr;
    ready_dly <= 4'({$random(seed)});
    repeat (3) @(posedge mclk);
    exp_queue.push_back(expect_cfg(s, hl, eth, pr));
    sys_rst <= 1'b0;
    while (cfg_done !== 1'b1) begin
      @(posedge mclk);
    end
    repeat (3) @(posedge mclk);
    if (eth && hl == 3'h0) exp_inv = 1'b1;
  endtask
  // ==========================================================
  // Monitor: each new configuration result meets the oldest note
  always @(posedge mclk) begin
    #1;
    got_cfg = {18'h0, load_defaults, run_program, autorun_en, proto_mode, axis_id,
      motion_error_register[MERR_DEFAULTS_BIT]};
    if (cfg_done === 1'b1 && !seen_done) begin
      check("cfg_result", exp_queue.pop_front(), got_cfg);
    end
    seen_done = (cfg_done === 1'b1);
  end
  // Watchdog well beyond the expected several hundred cycles
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    finish_test();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge mclk);
    check("reset_axis_id", 32'hFF, {24'h0, axis_id});
    wipe_nv <= 1'b0;
    foreach (cases[i]) power_on(cases[i], 3'h5, 1'b0, 1'b1);
    for (k = 0; k < 20; k++) begin
      power_on({3'({$random(seed)} % 7), 3'({$random(seed)} % 7), 3'({$random(seed)} % 7)},
        3'({$random(seed)} % 7 + 1), 1'b0, 1'($random(seed)));
    end
    // Status word layout, alias idle on CAN, unmapped offset
    power_on(9'o312, 3'h6, 1'b0, 1'b1);
    ahb(1'b0, REG_CFG_STATUS, 32'h0);
    check("cfg_status", 32'h091B, rd);
    check("can_alias", 32'h0, {16'h0, station_alias});
    ahb(1'b0, 8'h1C, 32'h0);
    check("unmapped", 32'h0, rd);
    // Interrupt: raise, mask in, clear
    check("irq_masked", 32'h0, {31'h0, irq});
    ahb(1'b0, REG_IRQ_STATUS, 32'h0);
    check("irq_status", 32'h1, rd & 32'h1);
    ahb(1'b1, REG_IRQ_MASK, 32'h1);
    repeat (2) @(posedge mclk);
    check("irq_on", 32'h1, {31'h0, irq});
    ahb(1'b1, REG_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge mclk);
    check("irq_off", 32'h0, {31'h0, irq});
    // Hall lines grounded: no auto-start
    power_on(9'o306, 3'h0, 1'b0, 1'b1);
    ahb(1'b0, REG_IRQ_STATUS, 32'h0);
    check("irq_hall", 32'h3, rd);
    // Software disable through the store, then Hall lines no longer matter
    ahb(1'b1, REG_CTRL, 32'h5);
    @(posedge mclk);
    check("nv_wr", {NV_DISABLE_ADDR, NV_DISABLE_VAL}, {nv_wr.addr, nv_wr.data});
    exp_dis = 1'b1;
    power_on(9'o421, 3'h7, 1'b0, 1'b1);
    power_on(9'o421, 3'h0, 1'b0, 1'b1);
    wipe_nv <= 1'b1;
    @(posedge mclk);
    wipe_nv <= 1'b0;
    exp_dis = 1'b0;
    // EtherCAT: fixed CoE, software axis ID and station alias
    power_on(9'o444, 3'h3, 1'b1, 1'b1);
    check("alias_unset", 32'h0, {16'h0, station_alias});
    foreach (sw_ids[i]) begin
      ahb(1'b1, REG_AXIS_SW, {24'h0, sw_ids[i]});
      repeat (3) @(posedge mclk);
      check("sw_axis_id", {24'h0, sw_ids[i]}, {24'h0, axis_id});
      check("alias", (sw_ids[i] == 8'hFF) ? 32'h0 : {24'h0, sw_ids[i]},
        {16'h0, station_alias});
    end
    ahb(1'b1, REG_CTRL, 32'h6);
    repeat (3) @(posedge mclk);
    check("hw_axis_id", 32'hFF, {24'h0, axis_id});
    check("hw_alias", 32'h0, {16'h0, station_alias});
    // Grounded Hall lines invalidate the setup; next power-on loads defaults
    power_on(9'o000, 3'h0, 1'b1, 1'b0);
    ahb(1'b0, REG_IRQ_STATUS, 32'h0);
    check("irq_inval", 32'h5, rd);
    power_on(9'o000, 3'h2, 1'b1, 1'b0);
    ahb(1'b0, REG_MERR, 32'h0);
    check("merr", 32'h4, rd);
    finish_test();
  end
endmodule
`default_nettype wire
